// file: common/bstp_defines.vh
// Purpose: Constants for the boundary-scan test port
// Assumes: Included by its bare name from hw/bstp_tap.v
// Contract
// - Three test inputs, one output, optional reset
// - Test logic advances only on test clock
// - Scanning never disturbs the running core
// - Mode select sampled on rising test clock
// - Data in sampled on rising test clock
// - Data routed by prior mode-select sequence
// - Output shows selected path, changes falling
// - Output driver off when not shifting
// - Test reset clears controller and instruction
// - Three-bit instruction shifted in shift-IR, loaded in update-IR
// - Instruction selects active data register path
// - Only public standard instructions implemented
// - Boundary, bypass and identification registers only
// - Bypass is one flip-flop stage
// - Identification 32 bits, LSB out first
// - Boundary chain 118 cells, cell 0 first
// - Control cell one enables its driver
// - Chain order follows the pin table
`ifndef BSTP_DEFINES_VH
`define BSTP_DEFINES_VH

// ==========================================================
// Register widths
`define BSTP_IR_W        3
`define BSTP_ID_W        32
`define BSTP_BSR_W       118
`define BSTP_SYNC_W      3

// ==========================================================
// Instruction codes and reset values
`define BSTP_INS_EXTEST  3'h0
`define BSTP_INS_SAMPLE  3'h1
`define BSTP_INS_IDCODE  3'h2
`define BSTP_INS_BYPASS  3'h7
`define BSTP_IR_CAPTURE  3'h1
`define BSTP_IR_RESET    3'h2

// ==========================================================
// Controller states
`define BSTP_ST_TLR      4'h0
`define BSTP_ST_RTI      4'h1
`define BSTP_ST_SEL_DR   4'h2
`define BSTP_ST_CAP_DR   4'h3
`define BSTP_ST_SH_DR    4'h4
`define BSTP_ST_EX1_DR   4'h5
`define BSTP_ST_PA_DR    4'h6
`define BSTP_ST_EX2_DR   4'h7
`define BSTP_ST_UPD_DR   4'h8
`define BSTP_ST_SEL_IR   4'h9
`define BSTP_ST_CAP_IR   4'ha
`define BSTP_ST_SH_IR    4'hb
`define BSTP_ST_EX1_IR   4'hc
`define BSTP_ST_PA_IR    4'hd
`define BSTP_ST_EX2_IR   4'he
`define BSTP_ST_UPD_IR   4'hf

// ==========================================================
// Chain layout landmarks
`define BSTP_CELL_SO_LO_FIRST  0
`define BSTP_CELL_GODE         16
`define BSTP_CELL_BUS_FIRST    20
`define BSTP_CELL_IN_FIRST     68
`define BSTP_CELL_SO_HI_FIRST  102

`endif

// file: hw/bstp_tap.v
// Purpose: Boundary-scan test access port with bypass, id and chain
// Assumes: Test pins are asynchronous to i_clk and far slower than it
// Notes:   Test clock edges are found by oversampling on i_clk
`timescale 1ns/1ps
`default_nettype none
`include "bstp_defines.vh"

module bstp_tap
#(
  parameter [31:0] ID_CODE = 32'h0000_0001  // Arbitrary value, LSB set
)
(
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire         i_tck,
  input  wire         i_tms,
  input  wire         i_tdi,
  input  wire         i_trst_n,
  output reg          o_tdo,
  output reg          o_tdo_oe_n,
  input  wire [117:0] i_bsr_capture,
  output reg  [117:0] o_bsr_update,
  output reg          o_extest,
  output reg  [2:0]   o_instr,
  output reg  [3:0]   o_tap_state
);

  // ==========================================================
  // Pin synchronisers
  reg [`BSTP_SYNC_W-1:0] tck_sync_ff;
  reg [`BSTP_SYNC_W-1:0] tms_sync_ff;
  reg [`BSTP_SYNC_W-1:0] tdi_sync_ff;
  reg [`BSTP_SYNC_W-1:0] trst_sync_ff;
  reg                    tck_lvl_ff;
  reg                    tms_lvl_ff;
  reg                    tdi_lvl_ff;
  reg                    trst_lvl_ff;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tck_sync_ff  <= 3'h0;
      tms_sync_ff  <= 3'h7;
      tdi_sync_ff  <= 3'h7;
      trst_sync_ff <= 3'h0;
    end
    else
    begin
      tck_sync_ff  <= {tck_sync_ff[1:0], i_tck};
      tms_sync_ff  <= {tms_sync_ff[1:0], i_tms};
      tdi_sync_ff  <= {tdi_sync_ff[1:0], i_tdi};
      trst_sync_ff <= {trst_sync_ff[1:0], i_trst_n};
    end
  end

  // Level accepted once second and third stages agree
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tck_lvl_ff  <= 1'b0;
      tms_lvl_ff  <= 1'b1;
      tdi_lvl_ff  <= 1'b1;
      trst_lvl_ff <= 1'b0;
    end
    else
    begin
      if (tck_sync_ff[1] == tck_sync_ff[2])
        tck_lvl_ff <= tck_sync_ff[2];
      if (tms_sync_ff[1] == tms_sync_ff[2])
        tms_lvl_ff <= tms_sync_ff[2];
      if (tdi_sync_ff[1] == tdi_sync_ff[2])
        tdi_lvl_ff <= tdi_sync_ff[2];
      if (trst_sync_ff[1] == trst_sync_ff[2])
        trst_lvl_ff <= trst_sync_ff[2];
    end
  end

  wire tck_rise;
  wire tck_fall;
  wire test_rst;
  assign tck_rise = (tck_sync_ff[1] & tck_sync_ff[2]) & ~tck_lvl_ff;
  assign tck_fall = ~(tck_sync_ff[1] | tck_sync_ff[2]) & tck_lvl_ff;
  assign test_rst = ~trst_lvl_ff;

  // Mode select and data in as seen at the accepted rising edge
  wire tms_now;
  wire tdi_now;
  assign tms_now = (tms_sync_ff[1] == tms_sync_ff[2]) ? tms_sync_ff[2] : tms_lvl_ff;
  assign tdi_now = (tdi_sync_ff[1] == tdi_sync_ff[2]) ? tdi_sync_ff[2] : tdi_lvl_ff;

  // ==========================================================
  // Controller state machine
  reg [3:0] state_ff;
  reg [3:0] nxt_state;

  always @*
  begin
    case (state_ff)
      `BSTP_ST_TLR:
        if (tms_now)
          nxt_state = `BSTP_ST_TLR;
        else
          nxt_state = `BSTP_ST_RTI;
      `BSTP_ST_RTI:
        if (tms_now)
          nxt_state = `BSTP_ST_SEL_DR;
        else
          nxt_state = `BSTP_ST_RTI;
      `BSTP_ST_SEL_DR:
        if (tms_now)
          nxt_state = `BSTP_ST_SEL_IR;
        else
          nxt_state = `BSTP_ST_CAP_DR;
      `BSTP_ST_CAP_DR:
        if (tms_now)
          nxt_state = `BSTP_ST_EX1_DR;
        else
          nxt_state = `BSTP_ST_SH_DR;
      `BSTP_ST_SH_DR:
        if (tms_now)
          nxt_state = `BSTP_ST_EX1_DR;
        else
          nxt_state = `BSTP_ST_SH_DR;
      `BSTP_ST_EX1_DR:
        if (tms_now)
          nxt_state = `BSTP_ST_UPD_DR;
        else
          nxt_state = `BSTP_ST_PA_DR;
      `BSTP_ST_PA_DR:
        if (tms_now)
          nxt_state = `BSTP_ST_EX2_DR;
        else
          nxt_state = `BSTP_ST_PA_DR;
      `BSTP_ST_EX2_DR:
        if (tms_now)
          nxt_state = `BSTP_ST_UPD_DR;
        else
          nxt_state = `BSTP_ST_SH_DR;
      `BSTP_ST_UPD_DR:
        if (tms_now)
          nxt_state = `BSTP_ST_SEL_DR;
        else
          nxt_state = `BSTP_ST_RTI;
      `BSTP_ST_SEL_IR:
        if (tms_now)
          nxt_state = `BSTP_ST_TLR;
        else
          nxt_state = `BSTP_ST_CAP_IR;
      `BSTP_ST_CAP_IR:
        if (tms_now)
          nxt_state = `BSTP_ST_EX1_IR;
        else
          nxt_state = `BSTP_ST_SH_IR;
      `BSTP_ST_SH_IR:
        if (tms_now)
          nxt_state = `BSTP_ST_EX1_IR;
        else
          nxt_state = `BSTP_ST_SH_IR;
      `BSTP_ST_EX1_IR:
        if (tms_now)
          nxt_state = `BSTP_ST_UPD_IR;
        else
          nxt_state = `BSTP_ST_PA_IR;
      `BSTP_ST_PA_IR:
        if (tms_now)
          nxt_state = `BSTP_ST_EX2_IR;
        else
          nxt_state = `BSTP_ST_PA_IR;
      `BSTP_ST_EX2_IR:
        if (tms_now)
          nxt_state = `BSTP_ST_UPD_IR;
        else
          nxt_state = `BSTP_ST_SH_IR;
      `BSTP_ST_UPD_IR:
        if (tms_now)
          nxt_state = `BSTP_ST_SEL_DR;
        else
          nxt_state = `BSTP_ST_RTI;
      default:         nxt_state = `BSTP_ST_TLR;
    endcase
  end

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      state_ff <= `BSTP_ST_TLR;
    else if (test_rst)
      state_ff <= `BSTP_ST_TLR;
    else if (tck_rise)
      state_ff <= nxt_state;
  end

  // ==========================================================
  // Instruction register
  reg [2:0] ir_shift_ff;
  reg [2:0] ir_ff;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ir_shift_ff <= `BSTP_IR_CAPTURE;
      ir_ff       <= `BSTP_IR_RESET;
    end
    else if (test_rst || state_ff == `BSTP_ST_TLR)
    begin
      ir_shift_ff <= `BSTP_IR_CAPTURE;
      ir_ff       <= `BSTP_IR_RESET;
    end
    else if (tck_rise)
    begin
      case (state_ff)
        `BSTP_ST_CAP_IR: ir_shift_ff <= `BSTP_IR_CAPTURE;
        `BSTP_ST_SH_IR:  ir_shift_ff <= {tdi_now, ir_shift_ff[2:1]};
        default:         ir_shift_ff <= ir_shift_ff;
      endcase
      if (state_ff == `BSTP_ST_UPD_IR)
        ir_ff <= ir_shift_ff;
    end
  end

  // Decode: anything not public and known falls to bypass
  localparam [1:0] SEL_BYP = 2'h0;
  localparam [1:0] SEL_ID  = 2'h1;
  localparam [1:0] SEL_BSR = 2'h2;

  function [1:0] dr_select;
    input [2:0] code;
    begin
      case (code)
        `BSTP_INS_EXTEST: dr_select = SEL_BSR;
        `BSTP_INS_SAMPLE: dr_select = SEL_BSR;
        `BSTP_INS_IDCODE: dr_select = SEL_ID;
        default:          dr_select = SEL_BYP;
      endcase
    end
  endfunction

  wire [1:0] dr_sel;
  assign dr_sel = dr_select(ir_ff);

  // ==========================================================
  // Data registers
  reg                        byp_ff;
  reg [`BSTP_ID_W-1:0]       id_ff;
  reg [`BSTP_BSR_W-1:0]      bsr_ff;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      byp_ff <= 1'b0;
      id_ff  <= 32'h0000_0000;
      bsr_ff <= 118'h0;
    end
    else if (tck_rise && state_ff == `BSTP_ST_CAP_DR)
    begin
      byp_ff <= 1'b0;
      id_ff  <= ID_CODE;
      if (dr_sel == SEL_BSR)
        bsr_ff <= i_bsr_capture;
    end
    else if (tck_rise && state_ff == `BSTP_ST_SH_DR)
    begin
      case (dr_sel)
        SEL_BSR: bsr_ff <= {tdi_now, bsr_ff[117:1]};
        SEL_ID:  id_ff  <= {tdi_now, id_ff[31:1]};
        default: byp_ff <= tdi_now;
      endcase
    end
  end

  // Update stage holds chain contents off the shift path
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_bsr_update <= 118'h0;
    else if (tck_rise && state_ff == `BSTP_ST_UPD_DR && dr_sel == SEL_BSR)
      o_bsr_update <= bsr_ff;
  end

  // ==========================================================
  // Serial output, driven only while shifting
  wire shifting;
  reg  tdo_bit;
  assign shifting = (state_ff == `BSTP_ST_SH_DR) || (state_ff == `BSTP_ST_SH_IR);

  always @*
  begin
    if (state_ff == `BSTP_ST_SH_IR)
      tdo_bit = ir_shift_ff[0];
    else
    begin
      case (dr_sel)
        SEL_BSR: tdo_bit = bsr_ff[0];
        SEL_ID:  tdo_bit = id_ff[0];
        default: tdo_bit = byp_ff;
      endcase
    end
  end

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tdo      <= 1'b0;
      o_tdo_oe_n <= 1'b1;
    end
    else if (test_rst)
    begin
      o_tdo      <= 1'b0;
      o_tdo_oe_n <= 1'b1;
    end
    else if (tck_fall)
    begin
      o_tdo      <= shifting ? tdo_bit : 1'b0;
      o_tdo_oe_n <= ~shifting;
    end
  end

  // ==========================================================
  // Status toward the core
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_extest    <= 1'b0;
      o_instr     <= `BSTP_IR_RESET;
      o_tap_state <= `BSTP_ST_TLR;
    end
    else
    begin
      o_extest    <= (ir_ff == `BSTP_INS_EXTEST);
      o_instr     <= ir_ff;
      o_tap_state <= state_ff;
    end
  end

endmodule
`default_nettype wire

// file: sim/boundary_scan_test_port_bench.sv
// Purpose: Self-checking bench for the test access port
// Assumes: Controller model drives the test pins
// Notes:   Random data from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "bstp_defines.vh"
module boundary_scan_test_port_bench;
  localparam [31:0] ID = 32'h5a3c_96e1; // Arbitrary value
  logic         i_clk = 1'b0;
  logic         i_rst = 1'b1;
  logic         i_trst_n = 1'b1;
  logic         i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe_n, o_extest, b;
  logic [117:0] i_bsr_capture = '0;
  logic [117:0] o_bsr_update;
  logic [2:0]   o_instr;
  logic [3:0]   o_tap_state;
  logic [127:0] din, dout, mask;
  int           num_errors = 0;
  int           checks = 0;
  int           seed = 67885;
  int           n;
  always #2.5 i_clk = ~i_clk;
  bstp_tap #(.ID_CODE(ID)) i_bstp_tap(.i_clk(i_clk), .i_rst(i_rst), .i_tck(i_tck),
    .i_tms(i_tms), .i_tdi(i_tdi), .i_trst_n(i_trst_n), .o_tdo(o_tdo),
    .o_tdo_oe_n(o_tdo_oe_n), .i_bsr_capture(i_bsr_capture), .o_bsr_update(o_bsr_update),
    .o_extest(o_extest), .o_instr(o_instr), .o_tap_state(o_tap_state));
  bstp_ctl_model i_bstp_ctl_model(.i_tdo(o_tdo), .i_oe_n(o_tdo_oe_n), .o_tck(i_tck),
    .o_tms(i_tms), .o_tdi(i_tdi));
  // ==========================================================
  // Expectations and reporting
  function automatic logic [127:0] exp_out(input int c);
    if (c < 2) exp_out = {10'h0, i_bsr_capture};
    else if (c == 2) exp_out = {96'h0, ID};
    else exp_out = {din[126:0], 1'b0};
  endfunction
  task cmp(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge i_clk);
    #1 i_rst = 1'b0;
    repeat (8) @(posedge i_clk);
    #1 i_bstp_ctl_model.scan(1'b0, 32, {4{$random(seed)}}, dout);
    cmp(dout[31:0], ID);
    cmp(o_instr, `BSTP_IR_RESET);
    $display("test reset id done");
    for (int c = 0; c < 8; c++)
    begin
      i_bstp_ctl_model.scan(1'b1, 3, c, dout);
      cmp(dout[2:0], `BSTP_IR_CAPTURE);
      cmp(o_instr, c[2:0]);
      i_bsr_capture = {$random(seed), $random(seed), $random(seed), $random(seed)};
      din = {$random(seed), $random(seed), $random(seed), $random(seed)};
      n = (c < 2) ? 118 : 32;
      mask = (128'h1 << n) - 128'h1;
      i_bstp_ctl_model.scan(1'b0, n, din, dout);
      cmp(dout & mask, exp_out(c) & mask);
      if (c < 2) cmp(o_bsr_update, din[117:0]);
      cmp(o_extest, c == 0);
      $display("test code %0d done", c);
    end
    repeat (5) i_bstp_ctl_model.step(1'b1, 1'b1, b);
    #20 cmp(o_tap_state, `BSTP_ST_TLR);
    cmp(o_instr, `BSTP_IR_RESET);
    $display("test five high done");
    @(posedge i_clk);
    #1 i_bstp_ctl_model.scan(1'b1, 3, `BSTP_INS_BYPASS, dout);
    i_bstp_ctl_model.step(1'b0, 1'b1, b);
    i_trst_n = 1'b0;
    repeat (16) @(posedge i_clk);
    #1;
    cmp(o_tap_state, `BSTP_ST_TLR);
    cmp(o_instr, `BSTP_IR_RESET);
    i_trst_n = 1'b1;
    $display("test trst done");
    results;
  end
endmodule
`default_nettype wire

// file: sim/bstp_ctl_model.sv
// Purpose: External test controller driving the port pins
// Assumes: Caller starts steps just after an i_clk edge
// Notes:   Test clock period 80 ns, low between frames
`timescale 1ns/1ps
`default_nettype none
module bstp_ctl_model
(
  input  wire logic i_tdo,
  input  wire logic i_oe_n,
  output var  logic o_tck,
  output var  logic o_tms,
  output var  logic o_tdi
);
  // ==========================================================
  // Pin driving, clock low with mode select and data in high at start
  initial {o_tck, o_tms, o_tdi} = 3'b011;
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #40;
    tdo = i_oe_n ? 1'bx : i_tdo;
    o_tck = 1'b1;
    #40;
    o_tck = 1'b0;
  endtask
  // One scan from idle, ending back in idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic b;
    dout = '0;
    step(1'b0, 1'b1, b);
    step(1'b1, 1'b1, b);
    if (ir) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int k = 0; k < n; k++) step(k == n - 1, din[k], dout[k]);
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule
`default_nettype wire

// file: sim/bstp_tap_sva.sv
// Purpose: Port-level checks for the test access port
// Assumes: Sees only top-level ports of bstp_tap
// Notes:   Single clock domain, i_rst disables
`timescale 1ns/1ps
`default_nettype none
`include "bstp_defines.vh"
module bstp_tap_chk
(
  input wire logic         i_clk,
  input wire logic         i_rst,
  input wire logic         i_tck,
  input wire logic         i_tms,
  input wire logic         i_tdi,
  input wire logic         i_trst_n,
  input wire logic         o_tdo,
  input wire logic         o_tdo_oe_n,
  input wire logic [117:0] i_bsr_capture,
  input wire logic [117:0] o_bsr_update,
  input wire logic         o_extest,
  input wire logic [2:0]   o_instr,
  input wire logic [3:0]   o_tap_state
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  rst_state_a: assert property ($fell(i_rst) |-> o_tap_state == `BSTP_ST_TLR
    && o_instr == `BSTP_IR_RESET && o_tdo_oe_n) else $error("bad state after reset");
  trst_clear_a: assert property ((!i_trst_n)[*8] |-> o_tap_state == `BSTP_ST_TLR
    && o_instr == `BSTP_IR_RESET && o_tdo_oe_n) else $error("test reset ignored");
  oe_shift_a: assert property (!o_tdo_oe_n |-> o_tap_state inside {`BSTP_ST_SH_DR,
    `BSTP_ST_EX1_DR, `BSTP_ST_SH_IR, `BSTP_ST_EX1_IR}) else $error("driving outside shift");
  tdo_idle_a: assert property (o_tdo_oe_n |-> !o_tdo) else $error("data while off");
  state_tck_a: assert property ((!i_tck && i_trst_n)[*8] |-> $stable(o_tap_state))
    else $error("state moved without test clock");
  tdo_fall_a: assert property (i_tck[*8] |-> $stable(o_tdo) && $stable(o_tdo_oe_n))
    else $error("output moved while clock high");
  extest_flag_a: assert property ($stable(o_instr)[*2]
    |-> o_extest == (o_instr == `BSTP_INS_EXTEST)) else $error("extest flag wrong");
  instr_upd_a: assert property ($changed(o_instr) |-> o_tap_state inside
    {`BSTP_ST_UPD_IR, `BSTP_ST_RTI, `BSTP_ST_SEL_DR, `BSTP_ST_TLR}) else $error("instr moved");
  chain_upd_a: assert property ($changed(o_bsr_update) |-> o_instr <= 3'h1
    && o_tap_state inside {`BSTP_ST_UPD_DR, `BSTP_ST_RTI, `BSTP_ST_SEL_DR})
    else $error("chain update out of place");
  tlr_instr_a: assert property ((o_tap_state == `BSTP_ST_TLR)[*3]
    |-> o_instr == `BSTP_IR_RESET) else $error("reset state kept instr");
  cov_shift_c: cover property (o_tap_state == `BSTP_ST_SH_DR && !o_tdo_oe_n);
  cov_extest_c: cover property (o_extest);
  cov_trst_c: cover property ((!i_trst_n)[*6]);
endmodule
bind bstp_tap bstp_tap_chk i_bstp_tap_chk(.i_clk, .i_rst, .i_tck, .i_tms, .i_tdi,
  .i_trst_n, .o_tdo, .o_tdo_oe_n, .i_bsr_capture, .o_bsr_update, .o_extest, .o_instr,
  .o_tap_state);
`default_nettype wire
